// [rtl/rmc_pkg.sv]
/*
  Shared constants, types and ECC helpers of the memory RAS mode controller.
  Assumes one 100 MHz clock domain shared by host, channel PHYs and bus.
*/
package rmc_pkg;
  localparam int NCH = 3;
  localparam int NRANK = 4;
  localparam int LA_W = 24;
  localparam int ROW_W = 20;
  localparam int LINE_W = 512;
  localparam int CNT_W = 8;
  localparam int COPY_W = 16;
  localparam logic [1:0] CH_A = 2'h0;
  localparam logic [1:0] CH_B = 2'h1;
  localparam logic [1:0] CH_C = 2'h2;
  localparam logic [2:0] MASK_BC = 3'h6;
  localparam logic [1:0] MODE_INDEP = 2'h0;
  localparam logic [1:0] MODE_MIRROR = 2'h1;
  localparam logic [1:0] MODE_LOCK = 2'h2;
  localparam logic [3:0] BEATS_INDEP = 4'h8;
  localparam logic [3:0] BEATS_LOCK = 4'h4;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THRESH = 8'h04;
  localparam logic [7:0] OFS_RSIZE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam int CTRL_SPARE = 2;
  localparam int CTRL_SCRUB = 3;
  localparam int CTRL_X8 = 4;
  localparam logic [7:0] THRESH_RST = 8'h0a;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_CMD = 3'h1, S_WDAT = 3'h2, S_RDAT = 3'h3, S_DONE = 3'h4, S_RESP = 3'h5
  } rmc_state_type;
  typedef struct packed {
    logic write;
    logic [LA_W-1:0] addr;
    logic [LINE_W-1:0] wdata;
  } rmc_req_type;
  typedef struct packed {
    logic valid;
    logic err;
    logic ce;
    logic ue;
    logic [LINE_W-1:0] rdata;
  } rmc_resp_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] rank;
    logic [ROW_W-1:0] row;
  } rmc_mcmd_type;
  typedef struct packed {
    logic sparing_failover_event;
    logic mirroring_failover_event;
    logic ce_log;
    logic [1:0] chan;
    logic [1:0] rank;
  } rmc_evt_type;
  typedef struct packed {
    logic ce;
    logic ue;
    logic [63:0] data;
  } rmc_ecc_type;

  // Hamming check bits plus overall parity in bit 7
  function automatic logic [7:0] ecc_gen(input logic [63:0] d);
    logic [6:0] c;
    logic [6:0] p;
    c = 7'h00;
    p = 7'h02;
    for (int i = 0; i < 64; i++) begin
      p = p + 7'h01;
      if ((p & (p - 7'h01)) == 7'h00) p = p + 7'h01;
      if (d[i]) c = c ^ p;
    end
    return {^{d, c}, c};
  endfunction

  // Single-bit errors are fixed; double-bit errors only flagged
  function automatic rmc_ecc_type ecc_dec(input logic [71:0] w);
    rmc_ecc_type r;
    logic [7:0] g;
    logic [6:0] syn;
    logic [6:0] p;
    g = ecc_gen(w[63:0]);
    syn = g[6:0] ^ w[70:64];
    r.data = w[63:0];
    r.ce = ^w;
    r.ue = !r.ce && (syn != 7'h00);
    p = 7'h02;
    for (int i = 0; i < 64; i++) begin
      p = p + 7'h01;
      if ((p & (p - 7'h01)) == 7'h00) p = p + 7'h01;
      if (r.ce && p == syn) r.data[i] = !r.data[i];
    end
    return r;
  endfunction

  // Largest rank by size code, lowest index on a tie
  function automatic logic [1:0] largest_rank(input logic [7:0] sz);
    int b;
    b = 0;
    for (int r = 1; r < NRANK; r++) begin
      if (sz[r*2 +: 2] > sz[b*2 +: 2]) b = r;
    end
    return 2'(b);
  endfunction
endpackage

// [rtl/rmc_ras_ctrl.sv]
/*
  Memory RAS mode controller: line requests to three ECC channels, sparing,
  mirroring, lockstep, demand scrub and an AXI4-Lite register slave.
  Assumes channel PHYs on the same clock accept commands and write beats
  without stall and return read beats in order after a read command.
*/
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
// Overview of operation
// - Independent mode: one channel, eight 8-byte beats
// - Same-direction beats go out with no gaps
// - Sparing reserves largest rank per channel
// - Per-rank error counters trip failover at threshold
// - Copy failing rank to spare, then remap
// - Failed rank disabled, channel counting then stops
// - Each sparing failover emits an event
// - Sparing runs per channel; in mirror and lockstep the remap follows the read channel only
// - Only first correctable error is logged
// - Mirrored writes go to B and C, skipping a disabled channel
// - Mirror uncorrectable error: retry partner, disable channel
// - Recovered mirror error reported as correctable
// - Each mirroring failover emits an event
// - Mirror mode counts errors like independent mode
// - Lockstep drives same address on B and C
// - Read data gathered whole before forwarding
// - Lockstep: 128-bit beats, four per channel
// - Device correction for x4, x8 only in lockstep
// - 8-bit Hamming code per 64-bit word
// - Corrected read data written back when enabled
module rmc_ras_ctrl #(
  parameter logic [rmc_pkg::COPY_W-1:0] COPY_LINES = 16'h0010
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Host cache-line port
  input wire logic host_req_valid,
  output logic host_req_ready,
  input wire rmc_pkg::rmc_req_type host_req,
  output rmc_pkg::rmc_resp_type host_resp,
  // Memory channels A, B, C
  output rmc_pkg::rmc_mcmd_type [rmc_pkg::NCH-1:0] mem_cmd,
  output logic [rmc_pkg::NCH-1:0] mem_wvalid,
  output logic [rmc_pkg::NCH-1:0][71:0] mem_wdata,
  input wire logic [rmc_pkg::NCH-1:0] mem_rvalid,
  input wire logic [rmc_pkg::NCH-1:0][71:0] mem_rdata,
  // Management events and status
  output rmc_pkg::rmc_evt_type mgmt_event,
  output logic single_device_correction
);
  import rmc_pkg::*;

  typedef struct packed {
    rmc_state_type st;
    logic [3:0] beat;
    logic [LA_W-1:0] addr;
    logic is_wr;
    logic [1:0] chan;
    logic [1:0] rank;
    logic [NCH-1:0] tgt;
    logic [LINE_W-1:0] line;
    logic [NCH-1:0] ce_ch;
    logic ue;
    logic reclass;
    logic err;
    logic copying;
    logic [COPY_W-1:0] copy_idx;
    logic [1:0] mode;
    logic spare_en;
    logic scrub_en;
    logic dev_x8;
    logic [7:0] thr;
    logic [23:0] rsize;
    logic locked;
    logic first_ce;
    logic [NCH-1:0] dis;
    logic [NCH-1:0] spared;
    logic [NCH-1:0] pend;
    logic [NCH-1:0][1:0] frank;
    logic [NCH-1:0][NRANK-1:0][CNT_W-1:0] cnt;
    rmc_mcmd_type [NCH-1:0] cmd;
    logic [NCH-1:0] wv;
    logic [NCH-1:0][71:0] wd;
    rmc_resp_type resp;
    rmc_evt_type evt;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rmc_st_type;

  rmc_st_type s;
  rmc_st_type n;
  logic [NCH-1:0][1:0] spare_rk;
  logic [3:0] nb;
  logic [1:0] rd_src;
  logic [1:0] req_ch;
  logic [1:0] req_rank;
  logic [1:0] partner;
  logic [1:0] pend_ch;
  logic req_err;
  logic [ROW_W-1:0] row;
  logic [63:0] word;
  logic [31:0] wmerge;
  rmc_ecc_type dec;
  int widx;
  int lch;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  // Ready outputs are combinational, valid and data outputs come straight from state
  assign host_req_ready = (s.st == S_IDLE) && !(|s.pend);
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready = !s.w_got && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign host_resp = s.resp;
  assign mem_cmd = s.cmd;
  assign mem_wvalid = s.wv;
  assign mem_wdata = s.wd;
  assign mgmt_event = s.evt;
  assign single_device_correction = !s.dev_x8 || s.mode == MODE_LOCK;

  // Next-state logic for datapath, error handling and register slave
  always_comb begin
    n = s;
    widx = 0;
    lch = 0;
    dec = '0;
    word = '0;
    n.cmd = '0;
    n.wv = '0;
    n.resp.valid = 1'b0;
    n.evt.sparing_failover_event = 1'b0;
    n.evt.mirroring_failover_event = 1'b0;
    n.evt.ce_log = 1'b0;
    for (int c = 0; c < NCH; c++) spare_rk[c] = largest_rank(s.rsize[c*8 +: 8]);
    nb = (s.mode == MODE_LOCK) ? BEATS_LOCK : BEATS_INDEP;
    rd_src = (s.mode == MODE_MIRROR && s.dis[CH_B]) ? CH_C : CH_B;
    partner = (s.chan == CH_B) ? CH_C : CH_B;
    req_rank = host_req.addr[3:2];
    unique case (host_req.addr[1:0])
      2'h1: req_ch = CH_B;
      2'h2: req_ch = CH_C;
      default: req_ch = CH_A;
    endcase
    if (s.mode != MODE_INDEP) req_ch = rd_src;
    req_err = s.spare_en && req_rank == spare_rk[req_ch];
    pend_ch = CH_A;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (s.pend[c]) pend_ch = 2'(c);
    end
    row = s.copying ? {4'h0, s.copy_idx} : s.addr[LA_W-1:4];

    unique case (s.st)
      S_IDLE: begin
        if (|s.pend) begin
          // Failover copy takes priority over host traffic
          n.copying = 1'b1;
          n.copy_idx = '0;
          n.is_wr = 1'b0;
          n.chan = pend_ch;
          n.rank = s.frank[pend_ch];
          n.tgt = (s.mode == MODE_LOCK) ? MASK_BC : 3'h1 << pend_ch;
          n.ce_ch = '0;
          n.ue = 1'b0;
          n.st = S_CMD;
        end else if (host_req_valid) begin
          n.locked = 1'b1;
          n.addr = host_req.addr;
          n.is_wr = host_req.write;
          n.line = host_req.wdata;
          n.ce_ch = '0;
          n.ue = 1'b0;
          n.reclass = 1'b0;
          n.err = req_err;
          n.chan = req_ch;
          n.rank = req_rank;
          if (s.spared[req_ch] && req_rank == s.frank[req_ch]) n.rank = spare_rk[req_ch];
          if (s.mode == MODE_INDEP) n.tgt = 3'h1 << req_ch;
          else if (s.mode == MODE_LOCK) n.tgt = MASK_BC;
          else if (host_req.write) n.tgt = MASK_BC & ~s.dis;
          else n.tgt = 3'h1 << rd_src;
          n.st = req_err ? S_RESP : S_CMD;
        end
      end
      S_CMD: begin
        // Lockstep pair gets one shared address
        for (int c = 0; c < NCH; c++) begin
          if (s.tgt[c]) begin
            n.cmd[c].valid = 1'b1;
            n.cmd[c].write = s.is_wr;
            n.cmd[c].rank = s.rank;
            n.cmd[c].row = row;
          end
        end
        n.beat = 4'h0;
        n.st = s.is_wr ? S_WDAT : S_RDAT;
      end
      S_WDAT: begin
        // One beat every cycle until the burst ends
        for (int c = 0; c < NCH; c++) begin
          widx = (s.mode == MODE_LOCK) ? 2 * int'(s.beat) + ((c == 2) ? 1 : 0) : int'(s.beat);
          word = s.line[widx*64 +: 64];
          if (s.tgt[c]) begin
            n.wv[c] = 1'b1;
            n.wd[c] = {ecc_gen(word), word};
          end
        end
        n.beat = s.beat + 4'h1;
        if (s.beat == nb - 4'h1) begin
          if (!s.copying) begin
            n.st = S_RESP;
          end else if (s.copy_idx == COPY_LINES - 16'h0001) begin
            // Copy done: spare now answers for the failing rank
            n.copying = 1'b0;
            n.spared[s.chan] = 1'b1;
            n.pend[s.chan] = 1'b0;
            n.evt.sparing_failover_event = 1'b1;
            n.evt.chan = s.chan;
            n.evt.rank = s.frank[s.chan];
            n.st = S_IDLE;
          end else begin
            n.copy_idx = s.copy_idx + 16'h0001;
            n.is_wr = 1'b0;
            n.rank = s.frank[s.chan];
            n.st = S_CMD;
          end
        end
      end
      S_RDAT: begin
        // Whole line is collected before anything is forwarded
        if (mem_rvalid[s.chan]) begin
          for (int l = 0; l < 2; l++) begin
            if (l == 0 || s.mode == MODE_LOCK) begin
              // Lockstep lanes are B then C, even when a copy runs for channel C
              lch = (l == 0) ? ((s.mode == MODE_LOCK) ? 1 : int'(s.chan)) : 2;
              widx = (s.mode == MODE_LOCK) ? 2 * int'(s.beat) + l : int'(s.beat);
              dec = ecc_dec(mem_rdata[lch]);
              n.line[widx*64 +: 64] = dec.data;
              if (dec.ce) n.ce_ch[lch] = 1'b1;
              if (dec.ue) n.ue = 1'b1;
            end
          end
          n.beat = s.beat + 4'h1;
          if (s.beat == nb - 4'h1) n.st = S_DONE;
        end
      end
      S_DONE: begin
        if (s.copying) begin
          n.is_wr = 1'b1;
          n.rank = spare_rk[s.chan];
          n.st = S_CMD;
        end else if (s.ue && s.mode == MODE_MIRROR && !s.reclass && !s.dis[partner]) begin
          // Retry on the mirror image and drop the bad channel
          n.dis[s.chan] = 1'b1;
          n.evt.mirroring_failover_event = 1'b1;
          n.evt.chan = s.chan;
          n.evt.rank = s.rank;
          n.reclass = 1'b1;
          n.ue = 1'b0;
          n.ce_ch = '0;
          n.chan = partner;
          n.tgt = 3'h1 << partner;
          n.st = S_CMD;
        end else begin
          // Counting is the same in every mode; threshold zero counts nothing
          for (int c = 0; c < NCH; c++) begin
            if (s.ce_ch[c] && s.thr != 8'h00 && !s.spared[c] && !s.pend[c]) begin
              if (s.cnt[c][s.rank] != {CNT_W{1'b1}})
                n.cnt[c][s.rank] = s.cnt[c][s.rank] + 8'h01;
              if (s.cnt[c][s.rank] + 8'h01 >= s.thr && s.spare_en) begin
                n.pend[c] = 1'b1;
                n.frank[c] = s.rank;
              end
            end
          end
          if (|s.ce_ch && s.scrub_en && !s.ue) begin
            // Demand scrub rewrites the corrected line before answering
            n.is_wr = 1'b1;
            n.tgt = (s.mode == MODE_INDEP) ? 3'h1 << s.chan : MASK_BC & ~s.dis;
            n.st = S_CMD;
          end else begin
            n.st = S_RESP;
          end
        end
      end
      S_RESP: begin
        n.resp.valid = 1'b1;
        n.resp.err = s.err;
        n.resp.ce = |s.ce_ch || s.reclass;
        n.resp.ue = s.ue;
        n.resp.rdata = s.line;
        if ((|s.ce_ch || s.reclass) && !s.first_ce) begin
          n.first_ce = 1'b1;
          n.evt.ce_log = 1'b1;
          n.evt.chan = s.chan;
          n.evt.rank = s.rank;
        end
        n.st = S_IDLE;
      end
      default: n.st = S_IDLE;
    endcase

    // Register write: address and data may arrive in either order
    if (s_axi_awvalid && !s.aw_got && !s.bvalid) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_got && !s.bvalid) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    wmerge = 32'h0;
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case (s.awaddr)
        OFS_CTRL: begin
          wmerge = merge({27'h0, s.dev_x8, s.scrub_en, s.spare_en, s.mode}, s.wdata, s.wstrb);
          n.scrub_en = wmerge[CTRL_SCRUB];
          if (!s.locked) begin
            // Configuration freezes once traffic has started
            n.mode = wmerge[1:0];
            n.spare_en = wmerge[CTRL_SPARE];
            n.dev_x8 = wmerge[CTRL_X8];
          end
        end
        OFS_THRESH: begin
          wmerge = merge({24'h0, s.thr}, s.wdata, s.wstrb);
          if (!s.locked) n.thr = wmerge[7:0];
        end
        OFS_RSIZE: begin
          wmerge = merge({8'h0, s.rsize}, s.wdata, s.wstrb);
          if (!s.locked) n.rsize = wmerge[23:0];
        end
        OFS_STATUS: n.bresp = RESP_OKAY;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (s.bvalid && s_axi_bready) n.bvalid = 1'b0;

    // Register read, answered one cycle after the address is taken
    if (s.rvalid && s_axi_rready) n.rvalid = 1'b0;
    if (s_axi_arvalid && !s.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL: n.rdata = {27'h0, s.dev_x8, s.scrub_en, s.spare_en, s.mode};
        OFS_THRESH: n.rdata = {24'h0, s.thr};
        OFS_RSIZE: n.rdata = {8'h0, s.rsize};
        OFS_STATUS: n.rdata = {14'h0, s.frank, s.locked, single_device_correction,
                               s.first_ce, s.pend, s.spared, s.dis};
        default: begin
          n.rdata = 32'h0;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // State register; reset value is a constant
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.scrub_en <= 1'b1;
      s.thr <= THRESH_RST;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence indep_wr_a;
    s.mode == MODE_INDEP && s.cmd[0].valid && s.cmd[0].write;
  endsequence
  sequence burst_a;
    s.wv[0] [*8] ##1 !s.wv[0];
  endsequence
  sequence lock_wr_b;
    s.mode == MODE_LOCK && s.cmd[1].valid && s.cmd[1].write;
  endsequence
  sequence burst_bc;
    (s.wv[1] && s.wv[2]) [*4] ##1 !s.wv[1];
  endsequence

  a_burst_back: assert property (indep_wr_a |=> burst_a)
    else $error("Channel A write burst not eight gapless beats");
  a_lock_split: assert property (lock_wr_b |=> burst_bc)
    else $error("Lockstep burst not four paired beats");
  a_lock_addr: assert property (s.mode == MODE_LOCK && s.cmd[1].valid |->
      s.cmd[2].valid && s.cmd[2].row == s.cmd[1].row && s.cmd[2].rank == s.cmd[1].rank)
    else $error("Lockstep address differs between B and C");
  a_mirror_both: assert property (s.mode == MODE_MIRROR && s.cmd[1].valid &&
      s.cmd[1].write && !s.copying && s.dis == 3'h0 |-> s.cmd[2].valid && s.cmd[2].write)
    else $error("Mirrored write missed channel C");
  a_spare_hidden: assert property (s.spare_en && !s.copying && !s.spared[0] &&
      s.cmd[0].valid |-> s.cmd[0].rank != spare_rk[0])
    else $error("Normal access reached the spare rank");
  a_sfo_report: assert property ($rose(s.spared[0]) |-> s.evt.sparing_failover_event && s.evt.chan == CH_A)
    else $error("Sparing failover without event");
  a_ce_once: assert property (s.first_ce |=> !s.evt.ce_log)
    else $error("Second correctable error logged");
  a_mfo_drop: assert property (s.evt.mirroring_failover_event |->
      $countones(s.dis) == $countones($past(s.dis)) + 1 && s.st == S_CMD)
    else $error("Mirroring failover did not disable one channel");
  a_count_stop: assert property (s.spared[0] |=> $stable(s.cnt[0]))
    else $error("Counting continued after sparing failover");
  a_ecc_word: assert property (s.wv[0] |-> s.wd[0][71:64] == ecc_gen(s.wd[0][63:0]))
    else $error("Stored check code does not match data");
endmodule // rmc_ras_ctrl

// [testbench/rmc_mem_model.sv]
/*
  Behavioural DDR3 channels A, B and C behind the RAS controller: stores beats, replays reads.
  Assumes beats follow their command on aclk, as the controller drives them.
*/
`timescale 1ns/100ps
module rmc_mem_model (
  // Controller side
  input wire logic aclk,
  input wire rmc_pkg::rmc_mcmd_type [rmc_pkg::NCH-1:0] mem_cmd,
  input wire logic [rmc_pkg::NCH-1:0] mem_wvalid,
  input wire logic [rmc_pkg::NCH-1:0][71:0] mem_wdata,
  output logic [rmc_pkg::NCH-1:0] mem_rvalid = '0,
  output logic [rmc_pkg::NCH-1:0][71:0] mem_rdata = '0,
  // Bench knobs: beats per read, stalls, injected bit flips
  input wire logic [3:0] nbeats,
  input wire logic slow,
  input wire logic [rmc_pkg::NCH-1:0][71:0] flip
);
  import rmc_pkg::*;

  logic [71:0] store [int];
  int key [NCH];
  int left [NCH];
  logic gap = 1'b0;

  // Stalls are shared by all channels so lockstep lanes stay aligned
  always @(posedge aclk) begin
    gap <= slow && !gap;
    for (int c = 0; c < NCH; c++) begin
      mem_rvalid[c] <= 1'b0;
      mem_rdata[c] <= ~mem_rdata[c]; // Idle data toggles, never a stale beat
      if (mem_cmd[c].valid) begin
        key[c] = {2'(c), mem_cmd[c].rank, mem_cmd[c].row, 4'h0};
        left[c] = mem_cmd[c].write ? 0 : int'(nbeats);
      end else if (mem_wvalid[c]) begin
        store[key[c]] = mem_wdata[c];
        key[c]++;
      end else if (left[c] > 0 && !gap) begin
        mem_rvalid[c] <= 1'b1;
        mem_rdata[c] <= (store.exists(key[c]) ? store[key[c]] : 72'h0) ^ flip[c];
        key[c]++;
        left[c]--;
      end
    end
  end
endmodule // rmc_mem_model

// [testbench/rmc_ras_ctrl_tb.sv]
/*
  Self-checking bench of the RAS controller: modes, ECC, mirroring and sparing.
  Assumes rmc_mem_model answers on the channels and AXI4-Lite reaches the registers.
*/
`timescale 1ns/100ps
module rmc_ras_ctrl_tb;
  import rmc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slow = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rq;
  logic [3:0] s_axi_wstrb = 4'hf, nbeats = 4'h8;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, bq, rrq;
  logic host_req_valid = 1'b0, host_req_ready, single_device_correction, h;
  rmc_req_type host_req = '0;
  rmc_resp_type host_resp, hq;
  rmc_mcmd_type [NCH-1:0] mem_cmd;
  logic [NCH-1:0] mem_wvalid, mem_rvalid;
  logic [NCH-1:0][71:0] mem_wdata, mem_rdata, flip = '0;
  rmc_evt_type mgmt_event;
  logic [511:0] d;
  logic [23:0] a;
  logic [21:0] crow [NCH];
  int num_errors = 0, cmp_count = 0, seed = 17354, cycles = 0, nsfo, nmfo, nlog, ch;
  int nwb [NCH], wfirst [NCH], wlast [NCH];

  // Short copy count keeps sparing failovers brief
  rmc_ras_ctrl #(.COPY_LINES(16'h0002)) i_dut (.*);
  rmc_mem_model i_mem (.*);

  // Clock
  initial forever #5 aclk = ~aclk;

  // Event and beat counters; a hung run is cut off here
  always @(posedge aclk) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      complete_run();
    end
    nsfo += int'(mgmt_event.sparing_failover_event);
    nmfo += int'(mgmt_event.mirroring_failover_event);
    nlog += int'(mgmt_event.ce_log);
    for (int c = 0; c < NCH; c++) begin
      if (mem_cmd[c].valid) crow[c] = {mem_cmd[c].rank, mem_cmd[c].row};
      if (mem_wvalid[c] && nwb[c] == 0) wfirst[c] = cycles;
      if (mem_wvalid[c]) wlast[c] = cycles;
      nwb[c] += int'(mem_wvalid[c]);
    end
  end

  task automatic complete_run();
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_line(input logic [511:0] got, input logic [511:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return host_req_ready;
      1: return host_resp.valid;
      2: return s_axi_arready;
      3: return s_axi_rvalid;
      default: return s_axi_bvalid;
    endcase
  endfunction

  // Sample between edges so answers are read while they stand
  task automatic wait_for(input int k);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      h = sig(k);
      {hq, bq, rq, rrq} = {host_resp, s_axi_bresp, s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      n++;
    end while (h !== 1'b1 && n < 2000);
    // An answer that never came is a failure, not a silent fall-through
    if (h !== 1'b1) check_word(32'(h), 32'h1);
  endtask

  task automatic reg_wr(input logic [7:0] ad, input logic [31:0] dt);
    logic ta, tw, da, dw;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    {da, dw} = 2'b00;
    do begin
      @(negedge aclk);
      {ta, tw} = {s_axi_awready, s_axi_wready};
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      {da, dw} = {da | ta, dw | tw};
    end while (!(da && dw));
    s_axi_bready <= 1'b1;
    wait_for(4);
    s_axi_bready <= 1'b0;
    check_word(32'(bq), 32'(RESP_OKAY));
  endtask

  task automatic reg_rd(input logic [7:0] ad);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= ad;
    wait_for(2);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    wait_for(3);
    s_axi_rready <= 1'b0;
  endtask

  task automatic host_op(input logic wr, input logic [23:0] ad, input logic [511:0] dt);
    host_req_valid <= 1'b1;
    host_req <= '{wr, ad, dt};
    wait_for(0);
    host_req_valid <= 1'b0;
    wait_for(1);
  endtask

  function automatic logic [511:0] rand_line();
    logic [511:0] r;
    for (int i = 0; i < 16; i++) r[32*i +: 32] = $random(seed);
    return r;
  endfunction

  // Write beats each channel should carry for a line in mode m
  function automatic int exp_beats(input int m, input int c, input logic [1:0] sel);
    if (m > 0) return (c == 0) ? 0 : ((m == 2) ? 4 : 8);
    return (c == ((sel == 2'h3) ? 0 : int'(sel))) ? 8 : 0;
  endfunction

  task automatic do_reset();
    aresetn <= 1'b0;
    {nsfo, nmfo, nlog} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Main sequence: one pass per mode, then sparing on channels A and B
  initial begin
    // Each mode needs its own reset: mode bits freeze at the first host request
    for (int m = 0; m < 3; m++) begin
      do_reset();
      nbeats <= (m == 2) ? 4'h4 : 4'h8;
      slow <= 1'(m);
      reg_rd(OFS_CTRL);
      check_word(rq, 32'h8);
      check_word(32'(single_device_correction), 32'h1);
      reg_rd(8'h10);
      check_word(32'(rrq), 32'(RESP_SLVERR));
      reg_wr(OFS_CTRL, 32'h18 | 32'(m));
      check_word(32'(single_device_correction), 32'(m == 2));
      a = 24'($random(seed));
      d = rand_line();
      nwb = '{0, 0, 0};
      host_op(1'b1, a, d);
      for (int c = 0; c < NCH; c++) begin
        check_word(nwb[c], exp_beats(m, c, a[1:0]));
        if (nwb[c] > 0) check_word(wlast[c] - wfirst[c] + 1, nwb[c]);
        if (nwb[c] > 0) check_word(32'(crow[c]), {a[3:2], a[23:4]});
      end
      host_op(1'b0, a, '0);
      check_line(hq.rdata, d);
      check_word(32'({hq.err, hq.ce, hq.ue}), 32'h0);
      ch = (m > 0) ? 1 : ((a[1:0] == 2'h3) ? 0 : int'(a[1:0]));
      flip[ch] <= (m == 1) ? 72'h81 : 72'h1 << ($random(seed) & 63);
      nwb = '{0, 0, 0};
      for (int r = 0; r < 2; r++) begin
        host_op(1'b0, a, '0);
        check_line(hq.rdata, d);
        check_word(32'({hq.ce, hq.ue}), (r == 1 && m == 1) ? 0 : 2);
      end
      if (m != 1) check_word(nwb[ch], 2 * nbeats);
      check_word(nlog, 1);
      check_word(nmfo, 32'(m == 1));
      flip <= '0;
      reg_wr(OFS_CTRL, 32'h0);
      reg_rd(OFS_CTRL);
      // Scrub enable stays writable; mode and device width stay frozen
      check_word(rq, 32'h10 | 32'(m));
    end
    do_reset();
    nbeats <= 4'h8;
    reg_wr(OFS_RSIZE, 32'hc0c0);
    reg_wr(OFS_THRESH, 32'h2);
    reg_wr(OFS_CTRL, 32'hc);
    host_op(1'b0, 24'h00000c, '0);
    check_word(32'(hq.err), 32'h1);
    for (int c = 0; c < 2; c++) begin
      a = {22'h0, 2'(c)};
      d = rand_line();
      host_op(1'b1, a, d);
      flip[c] <= 72'h1 << ($random(seed) & 63);
      repeat (3) begin
        host_op(1'b0, a, '0);
        check_line(hq.rdata, d);
      end
      check_word(nsfo, c + 1);
      check_word(32'({mgmt_event.chan, mgmt_event.rank}), c << 2);
      flip <= '0;
    end
    complete_run();
  end
endmodule // rmc_ras_ctrl_tb
